// >>> swr_osc_recovery_cfg.sv
// Top of the selective-wake oscillator trim and clock recovery registers.
// Assumes frame CRC was checked upstream; crc_ok_i gates writes.
`timescale 1ns/1ps
module swr_osc_recovery_cfg
    import swr_pkg::*;
(
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        sys_rst_i,
    input  wire logic        restart_i,
    // SPI
    input  wire logic        spi_cs_n_i,
    input  wire logic        spi_sck_i,
    input  wire logic        spi_mosi_i,
    output logic             spi_miso_o,
    input  wire logic        crc_ok_i,
    // Trim enable and calibration source
    input  wire logic [1:0]  trim_enable_i,
    input  wire logic [15:0] cal_value_i,
    input  wire logic        cal_load_i,
    input  wire logic [3:0]  edge_dist_i,
    // Outputs to the wake logic
    output logic             wake_receiver_select_o,
    output logic      [4:0]  temp_coef_trim_o,
    output logic      [6:0]  oscillator_coarse_trim_o,
    output logic      [1:0]  recovery_clock_select_o,
    output logic      [1:0]  filter_time_constant_select_o,
    output logic             recovery_enable_o,
    output logic      [5:0]  time_const_o,
    output logic      [3:0]  clk_div_o
);
    logic [15:0] trim_reg;
    logic [15:0] cdr_reg;
    logic [15:0] cal_reg;
    logic [31:0] frame;
    logic        frame_done;
    logic        frame_start;
    logic [15:0] out_shift;
    logic        sck_q;

    wire  [6:0]  f_addr    = frame[31:25];
    wire         f_write   = frame[24];
    wire  [15:0] f_data    = frame[23:8];
    wire         wr_ok     = frame_done & f_write & crc_ok_i;
    wire         unlocked  = (trim_enable_i == TRIM_UNLOCK);
    // R02 R03 R04 R17 writes gated by trim enable
    wire         trim_we   = wr_ok & (f_addr == ADDR_TRIM) & unlocked;
    wire         cdr_we    = wr_ok & (f_addr == ADDR_CDR);
    wire  [15:0] next_trim = f_data & TRIM_WMASK;
    wire  [15:0] next_cdr  = f_data & CDR_WMASK;
    // After seven rises the address sits in the low bits of the shifter
    wire  [6:0]  rd_addr   = out_shift[6:0];
    // R05 R09 readback, reserved as zero, unmapped as zero
    wire  [15:0] rd_data   = (rd_addr == ADDR_TRIM) ? (trim_reg & TRIM_WMASK) :
                             (rd_addr == ADDR_CAL)  ? cal_reg :
                             (rd_addr == ADDR_CDR)  ? (cdr_reg & CDR_WMASK) : 16'h0;

    swr_frame_rx u_rx (
        .clk_i         (clk_i),
        .sys_rst_i     (sys_rst_i),
        .spi_cs_n_i    (spi_cs_n_i),
        .spi_sck_i     (spi_sck_i),
        .spi_mosi_i    (spi_mosi_i),
        .frame_o       (frame),
        .frame_done_o  (frame_done),
        .frame_start_o (frame_start)
    );

    swr_filter_sel u_filt (
        .filt_sel_i   (cdr_reg[FILT_LSB +: 2]),
        .clk_sel_i    (cdr_reg[CLK_SEL_LSB +: 2]),
        .edge_dist_i  (edge_dist_i),
        .time_const_o (time_const_o),
        .clk_div_o    (clk_div_o)
    );

    // R06 R07 trim register reset and restart
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            trim_reg <= TRIM_RST;
        end else if (trim_we) begin
            trim_reg <= next_trim;
        end else if (restart_i) begin
            trim_reg <= trim_reg & TRIM_WMASK;
        end
    end

    // R13 R14 recovery control reset and restart
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            cdr_reg <= CDR_RST;
        end else if (cdr_we) begin
            cdr_reg <= next_cdr;
        end else if (restart_i) begin
            cdr_reg <= cdr_reg & CDR_WMASK;
        end
    end

    // R15 calibration word held from the trim source
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            cal_reg <= CAL_RST;
        end else if (cal_load_i) begin
            cal_reg <= cal_value_i;
        end
    end

    // Read data: address byte is captured live, data shifted out after it.
    // Limitation: reply word is the register addressed in the current frame.
    logic [5:0] bitcnt;
    logic [15:0] tx;
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            sck_q      <= 1'b0;
            bitcnt     <= 6'h0;
            out_shift  <= 16'h0;
            tx         <= 16'h0;
            spi_miso_o <= 1'b0;
        end else begin
            sck_q <= spi_sck_i;
            if (frame_start) begin
                bitcnt <= 6'h0;
            end else if (~spi_cs_n_i & spi_sck_i & ~sck_q) begin
                bitcnt    <= bitcnt + 6'h1;
                out_shift <= {out_shift[14:0], spi_mosi_i};
                if (bitcnt == 6'(DATA_LSB - 1)) begin
                    tx <= rd_data;
                end
            end else if (~spi_cs_n_i & ~spi_sck_i & sck_q & bitcnt >= 6'(DATA_LSB)) begin
                spi_miso_o <= tx[15];
                tx         <= {tx[14:0], 1'b0};
            end
        end
    end

    // R01 R10 R11 field outputs
    assign wake_receiver_select_o        = trim_reg[RX_SEL_BIT];
    assign temp_coef_trim_o              = trim_reg[11:7];
    assign oscillator_coarse_trim_o      = trim_reg[6:0];
    assign recovery_clock_select_o       = cdr_reg[CLK_SEL_LSB +: 2];
    assign filter_time_constant_select_o = cdr_reg[FILT_LSB +: 2];
    assign recovery_enable_o             = cdr_reg[EN_BIT];

    a_trim_locked: assert property (@(posedge clk_i) disable iff (sys_rst_i) // R17
        (wr_ok && f_addr == ADDR_TRIM && !unlocked && !restart_i) |=> $stable(trim_reg))
        else $error("trim changed while locked");
    a_trim_write: assert property (@(posedge clk_i) disable iff (sys_rst_i) // R03
        trim_we |=> trim_reg == $past(next_trim))
        else $error("trim write lost");
    a_rx_default: assert property (@(posedge clk_i) // R07
        sys_rst_i |=> !wake_receiver_select_o)
        else $error("receiver select not low-power after reset");
    a_cdr_reset: assert property (@(posedge clk_i) // R14
        sys_rst_i |=> cdr_reg == 16'h0004)
        else $error("recovery control reset wrong");
    a_trim_resv: assert property (@(posedge clk_i) disable iff (sys_rst_i) // R05
        (trim_reg & ~TRIM_WMASK) == 16'h0)
        else $error("trim reserved bit set");
    a_cdr_resv: assert property (@(posedge clk_i) disable iff (sys_rst_i) // R05
        (cdr_reg & 16'hff92) == 16'h0)
        else $error("recovery reserved bit set");
    a_restart_keep: assert property (@(posedge clk_i) disable iff (sys_rst_i) // R06
        (restart_i && !trim_we && !cdr_we) |=> $stable(trim_reg) && $stable(cdr_reg))
        else $error("restart altered fields");
    a_filter_adapt: assert property (@(posedge clk_i) disable iff (sys_rst_i) // R12
        (cdr_reg[3:2] == FILT_ADAPT && edge_dist_i == 4'h9) |-> time_const_o == 6'h08)
        else $error("adaptive constant wrong");
    a_cal_reset: assert property (@(posedge clk_i) // R15
        sys_rst_i |=> cal_reg == 16'h0000)
        else $error("calibration reset wrong");
    a_enable_out: assert property (@(posedge clk_i) disable iff (sys_rst_i) // R13
        cdr_we |=> recovery_enable_o == $past(f_data[0]))
        else $error("enable not written");
    a_rx_sel_locked: assert property (@(posedge clk_i) disable iff (sys_rst_i) // R02
        (wr_ok && f_addr == ADDR_TRIM && !unlocked) |=> $stable(wake_receiver_select_o))
        else $error("receiver select changed while locked");
    a_osc_locked: assert property (@(posedge clk_i) disable iff (sys_rst_i) // R04
        (wr_ok && f_addr == ADDR_TRIM && !unlocked) |=> $stable(oscillator_coarse_trim_o))
        else $error("oscillator trim changed while locked");
    a_trim_reset: assert property (@(posedge clk_i) // R06
        sys_rst_i |=> trim_reg == 16'h0000)
        else $error("trim reset wrong");
    a_cal_readonly: assert property (@(posedge clk_i) disable iff (sys_rst_i) // R09
        (frame_done && f_write && f_addr == ADDR_CAL && !cal_load_i) |=> $stable(cal_reg))
        else $error("calibration written over the bus");
    a_clk_div_fast: assert property (@(posedge clk_i) disable iff (sys_rst_i) // R10
        (recovery_clock_select_o == 2'h0) |-> (clk_div_o == 4'h1))
        else $error("fastest recovery clock divisor wrong");
    a_clk_div_slow: assert property (@(posedge clk_i) disable iff (sys_rst_i) // R10
        (recovery_clock_select_o == 2'h3) |-> (clk_div_o == 4'h8))
        else $error("slowest recovery clock divisor wrong");
    a_filter_default: assert property (@(posedge clk_i) disable iff (sys_rst_i) // R11
        (filter_time_constant_select_o == 2'h1) |-> (time_const_o == 6'h10))
        else $error("default filter constant wrong");
    a_filter_write: assert property (@(posedge clk_i) disable iff (sys_rst_i) // R11
        cdr_we |=> filter_time_constant_select_o == $past(f_data[3:2]))
        else $error("filter select not written");
    a_adapt_short: assert property (@(posedge clk_i) disable iff (sys_rst_i) // R12
        (filter_time_constant_select_o == FILT_ADAPT &&
         edge_dist_i >= 4'h2 && edge_dist_i <= 4'h3) |-> (time_const_o == 6'h20))
        else $error("adaptive constant for short distance wrong");
    a_bad_crc: assert property (@(posedge clk_i) disable iff (sys_rst_i) // R16
        (frame_done && f_write && !crc_ok_i) |=> $stable(trim_reg) && $stable(cdr_reg))
        else $error("write taken despite bad check byte");
    a_miso_reset: assert property (@(posedge clk_i) // R16
        sys_rst_i |=> !spi_miso_o)
        else $error("read data line not low after reset");
endmodule

// >>> swr_pkg.sv
// Constants for the selective-wake trim and clock recovery register bank.
// Assumes a 32-bit SPI frame: address/mode byte, two data bytes, CRC byte.
// Operation
// R01: Bit 14 picks wake receiver: 0 low-power, 1 standard receiver.
// R02: Receiver select changes only while trim enable equals 11.
// R03: Temperature trim bits 11:7 writable only while trim enable equals 11.
// R04: Oscillator trim bits 6:0 writable only while trim enable equals 11.
// R05: Reserved bits always read zero in both control registers.
// R06: Reset clears trim register; restart clears bits 15, 13, 12 only.
// R07: Receiver select defaults to low-power receiver after reset.
// R08: Software treats oscillator trim as non-monotonic and avoids changing it.
// R09: Calibration register reads high byte 15:8 and low byte 7:0.
// R10: Clock select bits 6:5 choose 75, 37.5, 18.75 or 9.375 MHz.
// R11: Filter select bits 3:2 choose constant 8, 16 or 32.
// R12: Filter value 11 adapts constant to falling-edge distance.
// R13: Bit 0 enables clock-data recovery.
// R14: Reset loads recovery control 0x0004; restart keeps only writable fields.
// R15: Calibration register resets to zero; restart leaves it undefined.
// R16: Each access is one four-byte frame: address+mode, two data, CRC.
// R17: Protected trim writes without trim enable 11 are ignored.
package swr_pkg;
    localparam logic [6:0]  ADDR_TRIM      = 7'h3c;
    localparam logic [6:0]  ADDR_CAL       = 7'h3d;
    localparam logic [6:0]  ADDR_CDR       = 7'h3e;
    localparam logic [1:0]  TRIM_UNLOCK    = 2'h3;
    localparam int          RX_SEL_BIT     = 14;
    localparam logic [15:0] TRIM_WMASK     = 16'h4fff;
    localparam logic [15:0] TRIM_RST       = 16'h0000;
    localparam logic [15:0] CDR_WMASK      = 16'h006d;
    localparam logic [15:0] CDR_RST        = 16'h0004;
    localparam logic [15:0] CAL_RST        = 16'h0000;
    localparam int          CLK_SEL_LSB    = 5;
    localparam int          FILT_LSB       = 2;
    localparam int          EN_BIT         = 0;
    localparam logic [1:0]  FILT_ADAPT     = 2'h3;
    localparam logic [5:0]  TC_8           = 6'h08;
    localparam logic [5:0]  TC_16          = 6'h10;
    localparam logic [5:0]  TC_32          = 6'h20;
    localparam logic [3:0]  DIST_SHORT_MAX = 4'h3;
    localparam logic [3:0]  DIST_MID_MAX   = 4'h8;
    localparam int          FRAME_BITS     = 32;
    localparam int          MODE_BIT       = 7;
    localparam int          DATA_LSB       = 8;
endpackage

// >>> swr_filter_sel.sv
// Recovery filter time constant and clock divisor decode.
// Assumes edge distance comes from the recovery logic, in bits.
`timescale 1ns/1ps
module swr_filter_sel
    import swr_pkg::*;
(
    // Settings
    input  wire logic [1:0] filt_sel_i,
    input  wire logic [1:0] clk_sel_i,
    input  wire logic [3:0] edge_dist_i,
    // Decoded
    output logic      [5:0] time_const_o,
    output logic      [3:0] clk_div_o
);
    logic [5:0] adapt_tc;

    // R12 adaptive constant
    assign adapt_tc = (edge_dist_i <= DIST_SHORT_MAX) ? TC_32 :
                      (edge_dist_i <= DIST_MID_MAX)   ? TC_16 : TC_8;
    // R11 fixed constants
    assign time_const_o = (filt_sel_i == 2'h0) ? TC_8  :
                          (filt_sel_i == 2'h1) ? TC_16 :
                          (filt_sel_i == 2'h2) ? TC_32 : adapt_tc;
    // R10 divide 75 MHz source by 1, 2, 4 or 8
    assign clk_div_o = 4'h1 << clk_sel_i;
endmodule

// >>> swr_frame_rx.sv
// SPI frame shifter: collects 32 bits, MSB first, and flags frame end.
// Assumes sck and cs are already synchronous to clk_i.
`timescale 1ns/1ps
module swr_frame_rx
    import swr_pkg::*;
(
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        sys_rst_i,
    // SPI
    input  wire logic        spi_cs_n_i,
    input  wire logic        spi_sck_i,
    input  wire logic        spi_mosi_i,
    // Frame
    output logic      [31:0] frame_o,
    output logic             frame_done_o,
    output logic             frame_start_o
);
    logic [31:0] shift;
    logic [5:0]  count;
    logic        sck_q;
    logic        cs_q;
    wire         rise   = spi_sck_i & ~sck_q & ~spi_cs_n_i;
    wire         cs_end = spi_cs_n_i & ~cs_q;

    assign frame_start_o = ~spi_cs_n_i & cs_q;

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            shift        <= 32'h0;
            count        <= 6'h0;
            sck_q        <= 1'b0;
            cs_q         <= 1'b1;
            frame_o      <= 32'h0;
            frame_done_o <= 1'b0;
        end else begin
            sck_q        <= spi_sck_i;
            cs_q         <= spi_cs_n_i;
            // R16 only a whole 32-bit frame counts
            frame_done_o <= cs_end && (count == 6'(FRAME_BITS));
            if (cs_end) begin
                frame_o <= shift;
            end
            // Count runs past 32 so an overlong frame never reads as whole
            if (frame_start_o) begin
                count <= 6'h0;
            end else if (rise && count != 6'h3f) begin
                shift <= {shift[30:0], spi_mosi_i};
                count <= count + 6'h1;
            end
        end
    end
endmodule

// >>> swr_host_model.sv
// Host side SPI master model for the trim and clock recovery registers.
// Assumes the host clock and the device clock are the same clk_i.
`timescale 1ns/1ps
module swr_host_model (
    // Clock
    input  wire logic clk_i,
    // SPI
    input  wire logic spi_miso_i,
    output logic      spi_cs_n_o,
    output logic      spi_sck_o,
    output logic      spi_mosi_o
);
    initial begin
        spi_cs_n_o = 1'b1;
        spi_sck_o  = 1'b0;
        spi_mosi_o = 1'b0;
    end
    task automatic xfer(input logic [6:0] a, input logic w, input logic [15:0] d,
                        output logic [15:0] rdata);
        logic [31:0] f;
        f = {a, w, d, 8'h00};
        @(posedge clk_i) #10 spi_cs_n_o = 1'b0;
        for (int i = 31; i >= 0; i--) begin
            spi_mosi_o = f[i];
            repeat (2) @(posedge clk_i);
            #10 spi_sck_o = 1'b1;
            if (i < 24 && i > 7) rdata[i-8] = spi_miso_i;
            repeat (2) @(posedge clk_i);
            #10 spi_sck_o = 1'b0;
        end
        repeat (2) @(posedge clk_i);
        // Released line shows the inverse, never a stale value
        #10 spi_cs_n_o = 1'b1;
        spi_mosi_o = ~spi_mosi_o;
        repeat (4) @(posedge clk_i);
    endtask
endmodule

// >>> swr_osc_recovery_cfg_tb.sv
// Self-checking bench for the trim and clock recovery register bank.
// Assumes a CRC checked upstream; crc_ok_i is driven here.
`timescale 1ns/1ps
module swr_osc_recovery_cfg_tb;
    import swr_pkg::*;
    logic        clk_i = 0, sys_rst_i = 1, restart_i = 0, crc_ok_i = 1, cal_load_i = 0;
    logic        spi_cs_n_i, spi_sck_i, spi_mosi_i, spi_miso_o, rx_sel, rec_en;
    logic [1:0]  trim_enable_i = 2'h0, clk_sel, filt_sel;
    logic [15:0] cal_value_i = 16'h0000, rd;
    logic [3:0]  edge_dist_i = 4'h0, cdiv;
    logic [4:0]  tc_trim;
    logic [6:0]  osc_trim;
    logic [5:0]  tconst;
    int          n_errors = 0, n_checks = 0;
    always #50 clk_i = ~clk_i;
    swr_osc_recovery_cfg uut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .restart_i(restart_i),
        .spi_cs_n_i(spi_cs_n_i), .spi_sck_i(spi_sck_i), .spi_mosi_i(spi_mosi_i),
        .spi_miso_o(spi_miso_o), .crc_ok_i(crc_ok_i), .trim_enable_i(trim_enable_i),
        .cal_value_i(cal_value_i), .cal_load_i(cal_load_i), .edge_dist_i(edge_dist_i),
        .wake_receiver_select_o(rx_sel), .temp_coef_trim_o(tc_trim),
        .oscillator_coarse_trim_o(osc_trim), .recovery_clock_select_o(clk_sel),
        .filter_time_constant_select_o(filt_sel), .recovery_enable_o(rec_en),
        .time_const_o(tconst), .clk_div_o(cdiv));
    swr_host_model host (.clk_i(clk_i), .spi_miso_i(spi_miso_o), .spi_cs_n_o(spi_cs_n_i),
        .spi_sck_o(spi_sck_i), .spi_mosi_o(spi_mosi_i));
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("FAIL %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic rdchk(input string what, input logic [6:0] a, input logic [15:0] exp);
        host.xfer(a, 1'b0, 16'h0000, rd);
        chk(what, exp, rd);
    endtask
    task automatic t_reset;
        rdchk("trim", ADDR_TRIM, 16'h0000);
        rdchk("cdr", ADDR_CDR, 16'h0004);
        rdchk("cal", ADDR_CAL, 16'h0000);
        chk("rx_sel", 16'h0000, {15'h0, rx_sel});
        chk("tconst rst", 16'h0010, {10'h0, tconst});
        $display("test reset done");
    endtask
    task automatic t_trim;
        host.xfer(ADDR_TRIM, 1'b1, 16'hffff, rd);
        rdchk("locked trim", ADDR_TRIM, 16'h0000);
        @(posedge clk_i) #10 trim_enable_i = 2'h3;
        host.xfer(ADDR_TRIM, 1'b1, 16'hffff, rd);
        rdchk("trim", ADDR_TRIM, 16'h4fff);
        chk("rx_sel", 16'h0001, {15'h0, rx_sel});
        chk("temp trim", 16'h001f, {11'h0, tc_trim});
        chk("osc trim", 16'h007f, {9'h0, osc_trim});
        // Enable one code short of the unlock value must still lock
        @(posedge clk_i) #10 trim_enable_i = 2'h2;
        host.xfer(ADDR_TRIM, 1'b1, 16'h0000, rd);
        rdchk("enable 10", ADDR_TRIM, 16'h4fff);
        $display("test trim done");
    endtask
    task automatic t_cdr;
        host.xfer(ADDR_CDR, 1'b1, 16'hffff, rd);
        rdchk("cdr", ADDR_CDR, 16'h006d);
        chk("enable", 16'h0001, {15'h0, rec_en});
        for (int k = 0; k < 4; k++) begin
            host.xfer(ADDR_CDR, 1'b1, {9'h0, k[1:0], 1'b0, k[1:0], 2'h1}, rd);
            chk("clk div", 16'(1 << k), {12'h0, cdiv});
            chk("clk sel", 16'(k), {14'h0, clk_sel});
            chk("filt sel", 16'(k), {14'h0, filt_sel});
            if (k < 3) chk("tconst", 16'(8 << k), {10'h0, tconst});
        end
        @(posedge clk_i) #10 edge_dist_i = 4'h2;
        #10 chk("adapt 2", 16'h0020, {10'h0, tconst});
        @(posedge clk_i) #10 edge_dist_i = 4'h3;
        #10 chk("adapt 3", 16'h0020, {10'h0, tconst});
        @(posedge clk_i) #10 edge_dist_i = 4'h4;
        #10 chk("adapt 4", 16'h0010, {10'h0, tconst});
        @(posedge clk_i) #10 edge_dist_i = 4'h8;
        #10 chk("adapt 8", 16'h0010, {10'h0, tconst});
        @(posedge clk_i) #10 edge_dist_i = 4'h9;
        #10 chk("adapt 9", 16'h0008, {10'h0, tconst});
        @(posedge clk_i) #10 edge_dist_i = 4'ha;
        #10 chk("adapt 10", 16'h0008, {10'h0, tconst});
        $display("test cdr done");
    endtask
    task automatic t_cal_restart;
        @(posedge clk_i) #10 cal_value_i = 16'ha5c3;
        cal_load_i = 1'b1;
        @(posedge clk_i) #10 cal_load_i = 1'b0;
        host.xfer(ADDR_CAL, 1'b1, 16'h0000, rd);
        rdchk("cal", ADDR_CAL, 16'ha5c3);
        @(posedge clk_i) #10 restart_i = 1'b1;
        @(posedge clk_i) #10 restart_i = 1'b0;
        rdchk("restart trim", ADDR_TRIM, 16'h4fff);
        rdchk("restart cdr", ADDR_CDR, 16'h006d);
        @(posedge clk_i) #10 sys_rst_i = 1'b1;
        @(posedge clk_i) #10 sys_rst_i = 1'b0;
        rdchk("cal rst", ADDR_CAL, 16'h0000);
        chk("rx_sel rst", 16'h0000, {15'h0, rx_sel});
        @(posedge clk_i) #10 crc_ok_i = 1'b0;
        host.xfer(ADDR_CDR, 1'b1, 16'h0000, rd);
        @(posedge clk_i) #10 crc_ok_i = 1'b1;
        rdchk("bad crc", ADDR_CDR, 16'h0004);
        chk("enable off", 16'h0000, {15'h0, rec_en});
        rdchk("unmapped", 7'h10, 16'h0000);
        $display("test restart done");
    endtask
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    initial begin
        repeat (3) @(posedge clk_i);
        #10 sys_rst_i = 1'b0;
        t_reset();
        t_trim();
        t_cdr();
        t_cal_restart();
        print_verdict();
    end
    // Some 23 frames of about 140 cycles fit well inside this span
    initial begin
        #2000000;
        n_errors++;
        print_verdict();
    end
endmodule
